// [inc/tksr_pkg.sv]
// Package with the constants and types of the touch key status responder.
package tksr_pkg;

  // Command codes.
  localparam logic [7:0] CMD_STATUS = 8'h37;
  localparam logic [7:0] CMD_GRP_SIGNAL = 8'h20;
  localparam logic [7:0] CMD_GRP_DELTA = 8'h21;
  localparam logic [7:0] CMD_GRP_REF = 8'h22;
  localparam logic [7:0] CMD_GRP_INTEG = 8'h25;
  localparam logic [7:0] CMD_KEY_ERR = 8'h65;
  localparam logic [7:0] CMD_GRP_ERR = 8'h45;
  localparam logic [7:0] CMD_FIRST_KEY = 8'h6B;
  localparam logic [7:0] CMD_GRP_TOUCH = 8'h4B;
  localparam logic [7:0] CMD_NEG_THRESH = 8'h01;
  localparam logic [7:0] CMD_GET_MODE = 8'h67;
  localparam logic [7:0] CMD_PUT_MODE = 8'h70;
  localparam logic [7:0] CMD_SCOPE_KEY = 8'h73;
  localparam logic [7:0] CMD_SCOPE_ALL = 8'h53;
  localparam logic [7:0] CMD_SCOPE_ROW = 8'h78;
  localparam logic [7:0] CMD_SCOPE_COL = 8'h79;

  localparam logic [7:0] NO_KEY_REPLY = 8'hFF;
  localparam logic [7:0] DELTA_MAX = 8'hFF;
  localparam logic [7:0] NTHR_MIN = 8'h04;
  localparam logic [7:0] NTHR_MAX = 8'h40;
  localparam logic [7:0] NTHR_RESET = 8'h0A;
  localparam logic [2:0] RECAL_TRIES = 3'h5;

  // Register map, byte addresses.
  localparam logic [3:0] ADDR_REF_HIGH = 4'h0;
  localparam logic [3:0] ADDR_REF_LOW = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_SCOPE = 4'hC;
  localparam logic [15:0] REF_HIGH_RESET = 16'hF000;
  localparam logic [15:0] REF_LOW_RESET = 16'h0100;
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_PUT_BIT = 9;
  localparam int SCOPE_MODE_LSB = 0;
  localparam int SCOPE_KEY_LSB = 4;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARG = 4'b0010,
    ST_SEND = 4'b0100,
    ST_BUSY = 4'b1000
  } tksr_fsm_t;

  typedef enum logic [1:0] {
    SC_ALL = 2'd0,
    SC_KEY = 2'd1,
    SC_ROW = 2'd2,
    SC_COL = 2'd3
  } tksr_scope_t;

endpackage : tksr_pkg

// [rtl/tksr_responder.sv]
// Command responder of the 16-key touch matrix sensor with its register slave.
`timescale 1ns/1ps
`default_nettype none
module tksr_responder
  import tksr_pkg::*;
#(
  parameter int unsigned EE_WRITE_CYCLES = 5000
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Host byte link, receive side.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  // Host byte link, transmit side.
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  // Sensing engine state.
  input wire logic [15:0] key_detect,
  input wire logic [15:0] key_recal,
  input wire logic [15:0] recal_fail,
  input wire logic [15:0] recal_pass,
  input wire logic [15:0][15:0] key_signal,
  input wire logic [15:0][15:0] key_reference,
  input wire logic [15:0][7:0] key_integ,
  input wire logic sync_fail,
  input wire logic ee_mismatch,
  // Setup outputs towards sensing and eeprom.
  output logic [15:0][7:0] neg_thresh,
  output logic ee_wr_valid,
  output logic [15:0] ee_wr_mask,
  output logic [7:0] ee_wr_value,
  // AXI4-Lite slave.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    tksr_fsm_t fsm;
    logic [7:0] cmd;
    logic [5:0] cnt;
    logic [5:0] len;
    tksr_scope_t scope;
    logic [1:0] sel_row;
    logic [1:0] sel_col;
    logic put_mode;
    logic [7:0] arg;
    logic [3:0] first;
    logic [15:0][2:0] fail_cnt;
    logic [15:0] fail_flag;
    logic [15:0][7:0] nthr;
    logic [31:0] ee_cnt;
    logic ee_wr_valid;
    logic [15:0] ee_mask;
    logic [7:0] ee_value;
    logic rx_ready;
    logic tx_valid;
    logic [7:0] tx_data;
    logic [15:0] ref_high;
    logic [15:0] ref_low;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tksr_state_t;

  tksr_state_t q;
  tksr_state_t next_q;

  logic [15:0][7:0] err_byte;
  logic [15:0] err_any;
  logic [7:0] gen_status;
  logic [3:0] sel_key;
  logic group_scope;
  logic [15:0] scope_mask;

  // Key number is row plus four times column.
  assign sel_key = {q.sel_col, q.sel_row};
  // A single-key scope is not a group scope, so signal, reference, delta and integrator group queries cover all keys.
  assign group_scope = (q.scope == SC_ROW) || (q.scope == SC_COL);

  always_comb begin
    for (int k = 0; k < 16; k++) begin
      err_byte[k] = 8'h00;
      err_byte[k][0] = q.fail_flag[k];
      err_byte[k][1] = key_recal[k];
      // Bounds come from software; recalibration masks both.
      err_byte[k][2] = !key_recal[k] &&
                       (key_reference[k] > q.ref_high);
      err_byte[k][3] = !key_recal[k] &&
                       (key_reference[k] < q.ref_low);
      err_any[k] = |err_byte[k];
      case (q.scope)
        SC_KEY: scope_mask[k] = (4'(k) == sel_key);
        SC_ROW: scope_mask[k] = (k[1:0] == q.sel_row);
        SC_COL: scope_mask[k] = (k[3:2] == q.sel_col);
        default: scope_mask[k] = 1'b1;
      endcase
    end
    gen_status = {3'b000, ee_mismatch, sync_fail, |err_any, |key_recal,
                  |key_detect};
  end

  // Key of the j-th entry of a group reply, in ascending key order.
  function automatic logic [3:0] group_key(input logic [3:0] j);
    logic [3:0] k;
    k = j;
    if (q.scope == SC_ROW) begin
      k = {j[1:0], q.sel_row};
    end else if (q.scope == SC_COL) begin
      k = {q.sel_col, j[1:0]};
    end
    return k;
  endfunction : group_key

  // Bitmap byte of a per-key vector following the current scope.
  function automatic logic [7:0] bitmap(input logic [15:0] v,
                                        input logic [1:0] idx);
    logic [7:0] b;
    b = 8'h00;
    case (q.scope)
      SC_KEY: b[0] = v[sel_key];
      SC_ROW: b[3:0] = {v[{2'd3, q.sel_row}], v[{2'd2, q.sel_row}],
                        v[{2'd1, q.sel_row}], v[{2'd0, q.sel_row}]};
      SC_COL: b[3:0] = v[{q.sel_col, 2'd0} +: 4];
      default: b[3:0] = v[{idx, 2'd0} +: 4];
    endcase
    return b;
  endfunction : bitmap

  function automatic logic [7:0] delta_of(input logic [3:0] k);
    logic [16:0] d;
    d = {1'b0, key_reference[k]} - {1'b0, key_signal[k]};
    if (d[16]) begin
      return 8'h00;
    end else if (d[15:8] != 8'h00) begin
      return DELTA_MAX;
    end
    return d[7:0];
  endfunction : delta_of

  // Reply byte number idx of the command held in q.cmd.
  function automatic logic [7:0] reply_at(input logic [5:0] idx);
    logic [7:0] r;
    logic [3:0] k;
    r = q.cmd;
    k = group_key(idx[4:1]);
    case (q.cmd)
      CMD_STATUS: r = gen_status;
      CMD_GRP_SIGNAL: r = idx[0] ? key_signal[k][15:8]
                                 : key_signal[k][7:0];
      CMD_GRP_REF: r = idx[0] ? key_reference[k][15:8]
                              : key_reference[k][7:0];
      CMD_GRP_DELTA: r = delta_of(group_key(idx[3:0]));
      CMD_GRP_INTEG: r = key_integ[group_key(idx[3:0])];
      CMD_KEY_ERR: r = err_byte[sel_key];
      CMD_GRP_ERR: r = (q.scope == SC_KEY) ? err_byte[sel_key]
                                           : bitmap(err_any, idx[1:0]);
      CMD_GRP_TOUCH: r = bitmap(key_detect, idx[1:0]);
      CMD_FIRST_KEY: begin
        if (key_detect == 16'h0000) begin
          r = NO_KEY_REPLY;
        end else begin
          r = {((key_detect & ~(16'h0001 << q.first)) != 16'h0000),
               3'b000, q.first};
        end
      end
      CMD_NEG_THRESH: r = q.put_mode ? q.cmd : q.nthr[sel_key];
      default: r = q.cmd;
    endcase
    return r;
  endfunction : reply_at

  // Reply length of a one-byte command; zero means unknown or two-byte.
  function automatic logic [5:0] reply_len(input logic [7:0] c);
    logic [5:0] n;
    case (c)
      CMD_STATUS, CMD_KEY_ERR, CMD_FIRST_KEY: n = 6'd1;
      CMD_GET_MODE, CMD_PUT_MODE, CMD_SCOPE_ALL: n = 6'd1;
      CMD_GRP_SIGNAL, CMD_GRP_REF: n = group_scope ? 6'd8 : 6'd32;
      CMD_GRP_DELTA, CMD_GRP_INTEG: n = group_scope ? 6'd4 : 6'd16;
      CMD_GRP_ERR, CMD_GRP_TOUCH: n = (q.scope == SC_ALL) ? 6'd4 : 6'd1;
      CMD_NEG_THRESH: n = q.put_mode ? 6'd0 : 6'd1;
      default: n = 6'd0;
    endcase
    return n;
  endfunction : reply_len

  function automatic logic two_byte(input logic [7:0] c);
    return (c == CMD_SCOPE_KEY) || (c == CMD_SCOPE_ROW) ||
           (c == CMD_SCOPE_COL) || ((c == CMD_NEG_THRESH) && q.put_mode);
  endfunction : two_byte

  always_comb begin
    logic [3:0] lowest;
    logic [7:0] clamp;
    logic [31:0] wval;
    logic [31:0] rval;
    next_q = q;
    lowest = 4'h0;
    clamp = q.arg;
    wval = 32'h0000_0000;
    rval = 32'h0000_0000;
    next_q.ee_wr_valid = 1'b0;

    // Failure counting per key: a pass or the fifth failure in a row restarts the run.
    for (int k = 15; k >= 0; k--) begin
      if (key_detect[k]) begin
        lowest = 4'(k);
      end
      if (recal_pass[k]) begin
        next_q.fail_cnt[k] = 3'h0;
        next_q.fail_flag[k] = 1'b0;
      end else if (recal_fail[k]) begin
        if (q.fail_cnt[k] == RECAL_TRIES - 3'h1) begin
          next_q.fail_flag[k] = 1'b1;
          next_q.fail_cnt[k] = 3'h0;
        end else begin
          next_q.fail_cnt[k] = q.fail_cnt[k] + 3'h1;
        end
      end
    end
    // The reported key stays until it releases, then the lowest active one.
    if (!key_detect[q.first]) begin
      next_q.first = lowest;
    end

    case (q.fsm)
      ST_IDLE: begin
        if (rx_valid) begin
          next_q.cmd = rx_data;
          next_q.cnt = 6'd0;
          if (rx_data == CMD_GET_MODE) begin
            next_q.put_mode = 1'b0;
          end else if (rx_data == CMD_PUT_MODE) begin
            next_q.put_mode = 1'b1;
          end else if (rx_data == CMD_SCOPE_ALL) begin
            next_q.scope = SC_ALL;
          end
          if (two_byte(rx_data)) begin
            next_q.fsm = ST_ARG;
          end else if (reply_len(rx_data) != 6'd0) begin
            next_q.len = reply_len(rx_data);
            next_q.fsm = ST_SEND;
            next_q.rx_ready = 1'b0;
          end
        end
      end
      ST_ARG: begin
        if (rx_valid) begin
          next_q.arg = rx_data;
          next_q.len = 6'd1;
          next_q.fsm = ST_SEND;
          next_q.rx_ready = 1'b0;
          case (q.cmd)
            CMD_SCOPE_KEY: begin
              next_q.scope = SC_KEY;
              next_q.sel_row = rx_data[1:0];
              next_q.sel_col = rx_data[3:2];
            end
            CMD_SCOPE_ROW: begin
              next_q.scope = SC_ROW;
              next_q.sel_row = rx_data[1:0];
            end
            CMD_SCOPE_COL: begin
              next_q.scope = SC_COL;
              next_q.sel_col = rx_data[1:0];
            end
            default: next_q.scope = q.scope;
          endcase
        end
      end
      ST_SEND: begin
        // The first byte goes out two cycles after the last command byte is taken.
        if (!q.tx_valid) begin
          next_q.tx_valid = 1'b1;
          next_q.tx_data = reply_at(6'd0);
        end else if (tx_ready) begin
          if (q.cnt + 6'd1 < q.len) begin
            next_q.cnt = q.cnt + 6'd1;
            next_q.tx_data = reply_at(q.cnt + 6'd1);
          end else begin
            next_q.tx_valid = 1'b0;
            next_q.fsm = ST_IDLE;
            next_q.rx_ready = 1'b1;
            if (q.cmd == CMD_NEG_THRESH && q.put_mode) begin
              if (q.arg < NTHR_MIN) begin
                clamp = NTHR_MIN;
              end else if (q.arg > NTHR_MAX) begin
                clamp = NTHR_MAX;
              end
              // New value is live once the echo has left.
              for (int k = 0; k < 16; k++) begin
                if (scope_mask[k]) begin
                  next_q.nthr[k] = clamp;
                end
              end
              next_q.ee_wr_valid = 1'b1;
              next_q.ee_mask = scope_mask;
              next_q.ee_value = clamp;
              next_q.ee_cnt = 32'(EE_WRITE_CYCLES);
              next_q.fsm = ST_BUSY;
              next_q.rx_ready = 1'b0;
            end
          end
        end
      end
      ST_BUSY: begin
        // Link bytes are refused while the eeprom write runs; sensing goes on.
        if (q.ee_cnt <= 32'h0000_0001) begin
          next_q.fsm = ST_IDLE;
          next_q.rx_ready = 1'b1;
        end else begin
          next_q.ee_cnt = q.ee_cnt - 32'h0000_0001;
        end
      end
      default: begin
        next_q.fsm = ST_IDLE;
        next_q.rx_ready = 1'b1;
        next_q.tx_valid = 1'b0;
      end
    endcase

    // AXI4-Lite write: address and data are taken together.
    next_q.awready = 1'b0;
    next_q.wready = 1'b0;
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (s_axi_awvalid && s_axi_wvalid && !q.bvalid && !q.awready) begin
      next_q.awready = 1'b1;
      next_q.wready = 1'b1;
      next_q.bvalid = 1'b1;
      next_q.bresp = RESP_OKAY;
      for (int b = 0; b < 4; b++) begin
        wval[8*b +: 8] = s_axi_wstrb[b] ? s_axi_wdata[8*b +: 8] : 8'h00;
      end
      if (s_axi_awaddr == ADDR_REF_HIGH) begin
        if (s_axi_wstrb[0]) next_q.ref_high[7:0] = wval[7:0];
        if (s_axi_wstrb[1]) next_q.ref_high[15:8] = wval[15:8];
      end else if (s_axi_awaddr == ADDR_REF_LOW) begin
        if (s_axi_wstrb[0]) next_q.ref_low[7:0] = wval[7:0];
        if (s_axi_wstrb[1]) next_q.ref_low[15:8] = wval[15:8];
      end else if (s_axi_awaddr != ADDR_STATUS &&
                   s_axi_awaddr != ADDR_SCOPE) begin
        next_q.bresp = RESP_SLVERR;
      end
    end

    // AXI4-Lite read.
    next_q.arready = 1'b0;
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid && !q.arready) begin
      next_q.arready = 1'b1;
      next_q.rvalid = 1'b1;
      next_q.rresp = RESP_OKAY;
      case (s_axi_araddr)
        ADDR_REF_HIGH: rval[15:0] = q.ref_high;
        ADDR_REF_LOW: rval[15:0] = q.ref_low;
        ADDR_STATUS: begin
          rval[7:0] = gen_status;
          rval[STAT_BUSY_BIT] = (q.fsm == ST_BUSY);
          rval[STAT_PUT_BIT] = q.put_mode;
        end
        ADDR_SCOPE: begin
          rval[SCOPE_MODE_LSB +: 2] = q.scope;
          rval[SCOPE_KEY_LSB +: 4] = sel_key;
        end
        default: next_q.rresp = RESP_SLVERR;
      endcase
      next_q.rdata = rval;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.fsm <= ST_IDLE;
      q.scope <= SC_ALL;
      q.rx_ready <= 1'b1;
      q.ref_high <= REF_HIGH_RESET;
      q.ref_low <= REF_LOW_RESET;
      for (int k = 0; k < 16; k++) begin
        q.nthr[k] <= NTHR_RESET;
      end
    end else begin
      q <= next_q;
    end
  end

  assign rx_ready = q.rx_ready;
  assign tx_valid = q.tx_valid;
  assign tx_data = q.tx_data;
  assign neg_thresh = q.nthr;
  assign ee_wr_valid = q.ee_wr_valid;
  assign ee_wr_mask = q.ee_mask;
  assign ee_wr_value = q.ee_value;
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

endmodule : tksr_responder
`default_nettype wire

// [verification/tksr_host.sv]
// Host model that sends command bytes and collects reply bytes.
`timescale 1ns/1ps
`default_nettype none
module tksr_host (
  // Clock.
  input wire logic aclk,
  // Byte link towards the responder.
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic [7:0] q [$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'hA5;
    tx_ready = 1'b1;
  end
  // Slow mode stalls every other cycle so replies must wait for the host.
  always @(posedge aclk) begin
    tx_ready <= slow ? !tx_ready : 1'b1;
    if (tx_valid && tx_ready) q.push_back(tx_data);
  end
  // A byte is offered once the responder is ready again, or after 20000 cycles of waiting.
  task automatic send(input logic [7:0] b);
    int t = 0;
    do begin
      @(posedge aclk);
      t++;
    end while (!rx_ready && t < 20000);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : send
endmodule : tksr_host
`default_nettype wire

// [verification/tksr_props.sv]
// Checker on the ports of the touch key status responder.
`timescale 1ns/1ps
`default_nettype none
module tksr_props
  import tksr_pkg::*;
#(
  parameter int unsigned EE_WRITE_CYCLES = 5000
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Host byte link.
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  // Sensing state and setup outputs.
  input wire logic [15:0] key_detect,
  input wire logic [15:0] key_recal,
  input wire logic sync_fail,
  input wire logic ee_mismatch,
  input wire logic [15:0][7:0] neg_thresh,
  input wire logic ee_wr_valid
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic take;
  logic thr_bad;
  assign take = rx_valid && rx_ready;
  always_comb begin
    thr_bad = 1'b0;
    for (int i = 0; i < 16; i++) begin
      thr_bad = thr_bad || neg_thresh[i] < NTHR_MIN || neg_thresh[i] > NTHR_MAX;
    end
  end
  a_status_timing: assert property (
    take && rx_data == CMD_STATUS |=> !rx_ready ##1 tx_valid)
    else $error("status reply late");
  a_status_upper: assert property (
    take && rx_data == CMD_STATUS |-> ##2 tx_data[7:5] == 3'h0)
    else $error("status upper bits set");
  a_status_flags: assert property (
    take && rx_data == CMD_STATUS |-> ##2 tx_data[4:3] ==
      {ee_mismatch, sync_fail} && tx_data[1:0] == {|key_recal, |key_detect})
    else $error("status flags wrong");
  a_reply_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte lost");
  a_first_none: assert property (
    take && rx_data == CMD_FIRST_KEY && key_detect == 16'h0000
      |-> ##2 tx_data == NO_KEY_REPLY)
    else $error("no key reply wrong");
  a_first_key: assert property (
    take && rx_data == CMD_FIRST_KEY && key_detect != 16'h0000 |-> ##2
      tx_data[6:4] == 3'h0 && key_detect[tx_data[3:0]] &&
      tx_data[7] == ($countones(key_detect) > 1))
    else $error("first key reply wrong");
  a_ee_busy: assert property (
    ee_wr_valid |-> !rx_ready ##1 !ee_wr_valid && !rx_ready)
    else $error("eeprom write not busy");
  a_thr_range: assert property (
    !thr_bad)
    else $error("threshold out of range");
endmodule : tksr_props
bind tksr_responder tksr_props #(
  .EE_WRITE_CYCLES(EE_WRITE_CYCLES)
) u_props (
  .aclk, .aresetn, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
  .tx_ready, .key_detect, .key_recal, .sync_fail, .ee_mismatch,
  .neg_thresh, .ee_wr_valid
);
`default_nettype wire

// [verification/touch_key_status_responder_bench.sv]
// Testbench of the touch key status responder.
`timescale 1ns/1ps
`default_nettype none
module touch_key_status_responder_bench;
  import tksr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, ee_wr_valid;
  logic sync_fail = 1'b1;
  logic ee_mismatch = 1'b0;
  logic [7:0] rx_data, tx_data, ee_wr_value;
  logic [15:0] key_detect = '0, key_recal = '0, recal_fail = '0, ee_wr_mask;
  logic [15:0] recal_pass = '0;
  logic [15:0][15:0] key_signal, key_reference;
  logic [15:0][7:0] key_integ, neg_thresh;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = '1;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int fails = 0, checks_done = 0, ee_pulses = 0;
  always #2 aclk = ~aclk;
  always @(posedge aclk) ee_pulses += int'(ee_wr_valid === 1'b1);
  tksr_responder #(.EE_WRITE_CYCLES(12)) u_dut (
    .aclk, .aresetn, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data,
    .tx_ready, .key_detect, .key_recal, .recal_fail, .recal_pass,
    .key_signal, .key_reference, .key_integ, .sync_fail, .ee_mismatch,
    .neg_thresh, .ee_wr_valid, .ee_wr_mask, .ee_wr_value, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tksr_host u_host (.aclk, .rx_valid, .rx_data, .rx_ready, .tx_valid,
    .tx_data, .tx_ready);
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : wrap_up
  // Extra cycles after the last byte catch a reply that runs too long.
  task automatic xact(input logic [7:0] c, input int arg, input int n);
    int t;
    u_host.q.delete();
    u_host.send(c);
    if (arg >= 0) u_host.send(arg[7:0]);
    for (t = 0; t < 600 && u_host.q.size() < n; t++) @(posedge aclk);
    repeat (4) @(posedge aclk);
    check("reply length", 32'(u_host.q.size()), 32'(n));
  endtask : xact
  task automatic cmd_echo(input logic [7:0] c, input int arg);
    xact(c, arg, 1);
    check("echo", u_host.q[0], c);
  endtask : cmd_echo
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask : axi_rd
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    r = s_axi_bresp;
  endtask : axi_wr
  // Scope code s: below 0 all keys, 0..3 a row, 4..7 a column.
  function automatic logic [7:0] grp(input logic [7:0] c, input int s, i);
    int j;
    int k;
    logic [16:0] d;
    j = (c == CMD_GRP_SIGNAL || c == CMD_GRP_REF) ? i / 2 : i;
    k = s < 0 ? j : (s < 4 ? s + 4 * j : 4 * (s - 4) + j);
    d = {1'b0, key_reference[k]} - {1'b0, key_signal[k]};
    case (c)
      CMD_GRP_SIGNAL: grp = key_signal[k][8 * (i % 2) +: 8];
      CMD_GRP_REF: grp = key_reference[k][8 * (i % 2) +: 8];
      CMD_GRP_DELTA: grp = d[16] ? 8'h00 : (|d[15:8] ? DELTA_MAX : d[7:0]);
      default: grp = key_integ[k];
    endcase
  endfunction : grp
  task automatic t_groups(input int s);
    logic [7:0] cs [4] = '{CMD_GRP_SIGNAL, CMD_GRP_DELTA, CMD_GRP_REF,
                           CMD_GRP_INTEG};
    int n;
    for (int c = 0; c < 4; c++) begin
      n = (s < 0 ? 16 : 4) * (c % 2 == 0 ? 2 : 1);
      u_host.slow <= c[0];
      xact(cs[c], -1, n);
      for (int i = 0; i < n; i++) begin
        check("group byte", u_host.q[i], grp(cs[c], s, i));
      end
    end
  endtask : t_groups
  task automatic t_touch;
    logic [7:0] b;
    @(posedge aclk);
    key_detect <= 16'h0048;
    xact(CMD_FIRST_KEY, -1, 1);
    b = u_host.q[0];
    check("first more", b[7:4], 4'h8);
    check("first hit", key_detect[b[3:0]], 1'b1);
    key_detect[b[3:0]] <= 1'b0;
    xact(CMD_FIRST_KEY, -1, 1);
    check("next key", u_host.q[0], b[3:0] == 4'h3 ? 8'h06 : 8'h03);
    key_detect <= 16'h0000;
    xact(CMD_FIRST_KEY, -1, 1);
    check("no key", u_host.q[0], NO_KEY_REPLY);
    key_detect <= 16'h0048;
    cmd_echo(CMD_SCOPE_ALL, -1);
    xact(CMD_GRP_TOUCH, -1, 4);
    for (int c = 0; c < 4; c++) begin
      check("touch map", u_host.q[c], {4'h0, key_detect[4 * c +: 4]});
    end
    cmd_echo(CMD_SCOPE_ROW, 2);
    xact(CMD_GRP_TOUCH, -1, 1);
    check("touch row", u_host.q[0], 8'h02);
    cmd_echo(CMD_SCOPE_KEY, 6);
    xact(CMD_GRP_TOUCH, -1, 1);
    check("touch key", u_host.q[0], 8'h01);
    key_detect <= 16'h0000;
  endtask : t_touch
  task automatic key_err(input int k, input logic [3:0] e);
    cmd_echo(CMD_SCOPE_KEY, k);
    xact(CMD_KEY_ERR, -1, 1);
    check("key error", u_host.q[0][3:0], e);
  endtask : key_err
  task automatic t_err;
    logic [1:0] r;
    logic [31:0] d;
    axi_rd(ADDR_REF_HIGH, d, r);
    check("high bound", d[15:0], REF_HIGH_RESET);
    axi_wr(ADDR_REF_HIGH, 32'h0000_8000, r);
    check("write resp", r, RESP_OKAY);
    axi_rd(4'h2, d, r);
    check("unmapped resp", r, RESP_SLVERR);
    key_reference[9] <= 16'h8001;
    key_reference[2] <= 16'h00FF;
    key_recal[2] <= 1'b1;
    for (int p = 1; p <= 5; p++) begin
      @(posedge aclk);
      recal_fail[5] <= 1'b1;
      @(posedge aclk);
      recal_fail[5] <= 1'b0;
      if (p >= 4) key_err(5, p == 5 ? 4'h1 : 4'h0);
    end
    key_err(9, 4'h4);
    key_err(2, 4'h2);
    key_recal[2] <= 1'b0;
    key_err(2, 4'h8);
    cmd_echo(CMD_SCOPE_ALL, -1);
    xact(CMD_GRP_ERR, -1, 4);
    for (int c = 0; c < 4; c++) begin
      check("error map", u_host.q[c], 32'h0002_0204 >> (8 * c) & 8'hFF);
    end
    cmd_echo(CMD_SCOPE_ROW, 1);
    xact(CMD_GRP_ERR, -1, 1);
    check("error row", u_host.q[0], 8'h06);
  endtask : t_err
  task automatic t_setup;
    int p;
    cmd_echo(CMD_PUT_MODE, -1);
    cmd_echo(CMD_SCOPE_ROW, 0);
    p = ee_pulses;
    cmd_echo(CMD_NEG_THRESH, 8'h50);
    check("busy", rx_ready, 1'b0);
    for (int k = 0; k < 16; k++) begin
      check("threshold", neg_thresh[k], k % 4 ? NTHR_RESET : NTHR_MAX);
    end
    check("writes", 32'(ee_pulses - p), 32'h0000_0001);
    check("write mask", ee_wr_mask, 16'h1111);
    check("write value", ee_wr_value, NTHR_MAX);
    cmd_echo(CMD_GET_MODE, -1);
    cmd_echo(CMD_SCOPE_KEY, 4);
    xact(CMD_NEG_THRESH, -1, 1);
    check("threshold get", u_host.q[0], NTHR_MAX);
  endtask : t_setup
  // Key 2 keeps its low reference, so the error flag survives the reset.
  task automatic t_reset;
    logic [1:0] r;
    logic [31:0] d;
    axi_rd(ADDR_SCOPE, d, r);
    check("scope reg", d, 32'h0000_0041);
    aresetn <= 1'b0;
    sync_fail <= 1'b0;
    ee_mismatch <= 1'b1;
    @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADDR_SCOPE, d, r);
    check("scope reset", d, 32'h0000_0000);
    xact(CMD_STATUS, -1, 1);
    check("status late", u_host.q[0], 8'h14);
    xact(CMD_GRP_TOUCH, -1, 4);
  endtask : t_reset
  initial begin
    repeat (40000) @(posedge aclk);
    fails++;
    wrap_up();
  end
  initial begin
    for (int k = 0; k < 16; k++) begin
      key_signal[k] = 16'h1100;
      key_reference[k] = 16'(16'h1000 + 16'h0030 * k);
      key_integ[k] = 8'(8'h80 + k);
    end
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    key_recal <= 16'h0100;
    key_detect <= 16'h0040;
    xact(CMD_STATUS, -1, 1);
    check("status", u_host.q[0] & 8'hFB, 8'h0B);
    key_recal <= 16'h0000;
    key_detect <= 16'h0000;
    t_groups(-1);
    cmd_echo(CMD_SCOPE_ROW, 1);
    t_groups(1);
    cmd_echo(CMD_SCOPE_COL, 2);
    t_groups(6);
    cmd_echo(CMD_SCOPE_KEY, 3);
    t_groups(-1);
    t_touch();
    t_err();
    t_setup();
    t_reset();
    wrap_up();
  end
endmodule : touch_key_status_responder_bench
`default_nettype wire
